//--- rtl/shsf_map.svh
`ifndef SHSF_MAP_SVH
`define SHSF_MAP_SVH
// host status register layout, offset 00h of the controller i/o space
`define SHSF_OFS_STATUS 3'h0
`define SHSF_RST_STATUS 8'h00
// value returned for any offset this block does not serve
`define SHSF_UNMAPPED_READ 8'h00
`define SHSF_BIT_BYTE 7
`define SHSF_BIT_SEM 6
`define SHSF_BIT_ALERT 5
`define SHSF_BIT_FAILED 4
`define SHSF_BIT_BUSERR 3
`define SHSF_BIT_DEVERR 2
`define SHSF_BIT_DONE 1
`define SHSF_BIT_BUSY 0
// flags that are reported interrupt sources
`define SHSF_IRQ_MASK 8'h3E
`endif

//--- rtl/shsf_pkg.sv
package shsf_pkg;
    typedef enum logic [1:0] {
        SHSF_SEM_FREE = 2'b00,
        SHSF_SEM_TAKEN = 2'b01
    } shsf_sem_t;
endpackage

//--- rtl/shsf_flag.sv
`include "shsf_map.svh"
////////////////////////////////////////////////////////////////////////
// one sticky write-one-to-clear flag; a set in the clearing cycle wins
module shsf_flag (
    input wire logic clk,
    input wire logic nrst,
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_o
);
    logic flag_ff;
    // set has priority so an event coinciding with a clear is kept
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flag_ff <= 1'b0;
        end else if (set_i) begin
            flag_ff <= 1'b1;
        end else if (clr_i) begin
            flag_ff <= 1'b0;
        end
    end
    assign flag_o = flag_ff;
endmodule

//--- rtl/shsf_top.sv
`include "shsf_map.svh"
////////////////////////////////////////////////////////////////////////
// Operation
// - after reset first semaphore read returns 0, later reads return 1
// - writing 1 to semaphore frees it; writing 0 does nothing
// - semaphore affects no other hardware behaviour
// - alert flag sets when alert input raises the interrupt
// - alert flag clears only by write 1, resume-well reset low or NRST low
// - alert flag never sets when alert pin used as general purpose io
// - kill request sets failed flag, an interrupt source
// - bus collision sets bus-error flag, an interrupt source
// - illegal command, unclaimed cycle or timeout sets device-error flag
// - writing 1 clears device-error or completion flag and drops interrupt
// - completion flag sets only on success with completion irq enabled
// - host-busy reads 1 during command execution, registered so it rises and falls one cycle late
// - status flags clear on write 1, unchanged on write 0
// - routing bit sends every interrupt source to management interrupt
module shsf_top (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic RESUME_WELL_RESET_N,
    input wire logic [2:0] ADDR,
    input wire logic RD_STB,
    input wire logic WR_STB,
    input wire logic [7:0] WDATA,
    output logic [7:0] RDATA,
    input wire logic ALERT_INPUT_N,
    input wire logic ALERT_AS_GPIO,
    input wire logic KILL_REQ,
    input wire logic COLLISION,
    input wire logic ILLEGAL_CMD,
    input wire logic UNCLAIMED_CYCLE,
    input wire logic DEVICE_TIMEOUT,
    input wire logic CMD_SUCCESS,
    input wire logic COMPLETION_IRQ_ENABLE,
    input wire logic BYTE_COMPLETE,
    input wire logic CMD_RUNNING,
    input wire logic ROUTE_TO_MGMT_IRQ,
    output logic IRQ,
    output logic SYSTEM_MGMT_IRQ_N
);
    logic sel_rd;
    logic sel_wr;
    logic [7:0] clr;
    logic [7:0] set;
    logic [7:0] flags;
    logic alert_rst_n;
    logic busy_ff;
    logic alert_seen_ff;
    logic irq_ff;
    logic mgmt_n_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic any_src;
    shsf_pkg::shsf_sem_t sem_ff;
    logic is_status;
    logic sem_free_req;
    logic alert_low;
    logic alert_fall;
    logic device_error_flag_evt;
    logic done_evt;
    logic [7:0] src_flags;
    logic [7:0] status_view;

    ////////////////////////////////////////////////////////////////////
    // register decode; only the status offset is served here
    assign is_status = (ADDR == `SHSF_OFS_STATUS);
    assign sel_rd = RD_STB && is_status;
    assign sel_wr = WR_STB && is_status;
    // write data doubles as the clear mask, so a written 0 touches nothing
    assign clr = sel_wr ? WDATA : 8'h00;
    assign sem_free_req = sel_wr && WDATA[`SHSF_BIT_SEM];

    ////////////////////////////////////////////////////////////////////
    // ownership semaphore: a read claims it, a written 1 frees it
    // it feeds only the read path, nothing else looks at it
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sem_ff <= shsf_pkg::SHSF_SEM_FREE;
        end else begin
            case (sem_ff)
                shsf_pkg::SHSF_SEM_FREE: begin
                    // a free request in the claiming cycle wins over the read
                    if (sel_rd && !sem_free_req) begin
                        sem_ff <= shsf_pkg::SHSF_SEM_TAKEN;
                    end
                end
                shsf_pkg::SHSF_SEM_TAKEN: begin
                    if (sem_free_req) begin
                        sem_ff <= shsf_pkg::SHSF_SEM_FREE;
                    end
                end
                default: begin
                    sem_ff <= shsf_pkg::SHSF_SEM_FREE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // alert edge: only a fresh fall of the alert input sets the flag
    // a level would re-arm the flag right after software clears it
    assign alert_low = !ALERT_INPUT_N;
    assign alert_fall = alert_low && !alert_seen_ff;
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            alert_seen_ff <= 1'b0;
        end else begin
            alert_seen_ff <= alert_low;
        end
    end

    // condensed event terms for the flag bank
    assign device_error_flag_evt = ILLEGAL_CMD || UNCLAIMED_CYCLE || DEVICE_TIMEOUT;
    assign done_evt = CMD_SUCCESS && COMPLETION_IRQ_ENABLE;

    // event sources per flag bit
    always_comb begin
        set = 8'h00;
        set[`SHSF_BIT_ALERT] = alert_fall && !ALERT_AS_GPIO;
        set[`SHSF_BIT_FAILED] = KILL_REQ;
        set[`SHSF_BIT_BUSERR] = COLLISION;
        set[`SHSF_BIT_DEVERR] = device_error_flag_evt;
        set[`SHSF_BIT_DONE] = done_evt;
        set[`SHSF_BIT_BYTE] = BYTE_COMPLETE;
    end

    // alert flag also dies with the resume-well reset
    // a combined reset term: the resume reset must arrive glitch free
    assign alert_rst_n = NRST && RESUME_WELL_RESET_N;

    ////////////////////////////////////////////////////////////////////
    // sticky flags for bits 7..1 except the semaphore
    // set wins over a same-cycle clear, so no event slips past a clear
    genvar gi;
    generate
        for (gi = 1; gi < 8; gi++) begin : g_flag
            if (gi == `SHSF_BIT_SEM) begin : g_none
                assign flags[gi] = 1'b0;
            end else begin : g_sticky
                shsf_flag u_flag (
                    .clk(CLK),
                    .nrst((gi == `SHSF_BIT_ALERT) ? alert_rst_n : NRST),
                    .set_i(set[gi]),
                    .clr_i(clr[gi]),
                    .flag_o(flags[gi])
                );
            end
        end
    endgenerate
    assign flags[`SHSF_BIT_BUSY] = busy_ff;

    ////////////////////////////////////////////////////////////////////
    // busy mirrors the sequencer; writes to it are ignored
    // bit 0 is no sticky flag: it is rebuilt from the sequencer each cycle
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= CMD_RUNNING;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read image: sticky flags, live semaphore and the busy mirror
    always_comb begin
        status_view = flags;
        status_view[`SHSF_BIT_SEM] = (sem_ff == shsf_pkg::SHSF_SEM_TAKEN);
    end

    // read data, registered one cycle after the read strobe
    // an unmapped offset reads as zero rather than holding stale data
    always_comb begin
        nxt_rdata = rdata_ff;
        if (RD_STB) begin
            case (ADDR)
                `SHSF_OFS_STATUS: begin
                    nxt_rdata = status_view;
                end
                default: begin
                    nxt_rdata = `SHSF_UNMAPPED_READ;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rdata_ff <= `SHSF_RST_STATUS;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign RDATA = rdata_ff;

    ////////////////////////////////////////////////////////////////////
    // request lines: level, held until every source flag is cleared
    // busy and the semaphore are masked off, byte-complete is not a source
    assign src_flags = flags & `SHSF_IRQ_MASK;
    assign any_src = |src_flags;
    // ordinary request, silent while routed to the management line
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= any_src && !ROUTE_TO_MGMT_IRQ;
        end
    end

    // management request is active low and idles high out of reset
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            mgmt_n_ff <= 1'b1;
        end else begin
            mgmt_n_ff <= !(any_src && ROUTE_TO_MGMT_IRQ);
        end
    end
    assign IRQ = irq_ff;
    assign SYSTEM_MGMT_IRQ_N = mgmt_n_ff;
endmodule

//--- tb/shsf_top_sva.sv
module shsf_top_sva (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic RESUME_WELL_RESET_N,
    input wire logic RD_STB,
    input wire logic WR_STB,
    input wire logic ALERT_INPUT_N,
    input wire logic ALERT_AS_GPIO,
    input wire logic KILL_REQ,
    input wire logic COLLISION,
    input wire logic ILLEGAL_CMD,
    input wire logic UNCLAIMED_CYCLE,
    input wire logic DEVICE_TIMEOUT,
    input wire logic CMD_RUNNING,
    input wire logic ROUTE_TO_MGMT_IRQ,
    input wire logic IRQ,
    input wire logic SYSTEM_MGMT_IRQ_N,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] RDATA
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    // either request line counts, so routing cannot hide a lost source
    wire logic any_irq = IRQ || !SYSTEM_MGMT_IRQ_N;
    a_kill_raises: assert property (KILL_REQ |-> ##2 any_irq) else $error("kill lost");
    a_coll_raises: assert property (COLLISION |-> ##2 any_irq) else $error("collision lost");
    a_deverr_raises: assert property ((ILLEGAL_CMD || UNCLAIMED_CYCLE || DEVICE_TIMEOUT) |-> ##2 any_irq)
        else $error("device error lost");
    a_alert_raises: assert property ($fell(ALERT_INPUT_N) && !ALERT_AS_GPIO && RESUME_WELL_RESET_N
        ##1 RESUME_WELL_RESET_N |=> any_irq) else $error("alert lost");
    a_route_mgmt: assert property (ROUTE_TO_MGMT_IRQ |=> !IRQ) else $error("irq while routed");
    a_route_plain: assert property (!ROUTE_TO_MGMT_IRQ |=> SYSTEM_MGMT_IRQ_N) else $error("mgmt while unrouted");
    a_busy_reads: assert property (RD_STB && ADDR == 3'h0 && CMD_RUNNING && $past(CMD_RUNNING) && $past(NRST)
        |=> RDATA[0]) else $error("busy not seen");
    a_irq_holds: assert property (IRQ && !ROUTE_TO_MGMT_IRQ && RESUME_WELL_RESET_N && !$past(WR_STB)
        && $past(RESUME_WELL_RESET_N) |=> IRQ) else $error("irq dropped");
endmodule

//--- tb/shsf_slave.sv
module shsf_slave (
    input wire logic clk,
    input wire logic go,
    input wire logic [1:0] res,
    output logic busy,
    output logic [3:0] ev = 4'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt_ff = 2'h0;
    // a bus transfer lasts three cycles; its outcome pulses once at the end
    always_ff @(posedge clk) begin
        ev <= 4'h0;
        if (go) cnt_ff <= 2'h3;
        else if (cnt_ff != 2'h0) begin
            cnt_ff <= cnt_ff - 2'h1;
            if (cnt_ff == 2'h1) ev <= 4'h1 << res;
        end
    end
    assign busy = cnt_ff != 2'h0;
endmodule

//--- tb/tb_smbus_host_status_flags.sv
bind shsf_top shsf_top_sva chk_u (
    .CLK(CLK),
    .NRST(NRST),
    .RESUME_WELL_RESET_N(RESUME_WELL_RESET_N),
    .RD_STB(RD_STB),
    .WR_STB(WR_STB),
    .ALERT_INPUT_N(ALERT_INPUT_N),
    .ALERT_AS_GPIO(ALERT_AS_GPIO),
    .KILL_REQ(KILL_REQ),
    .COLLISION(COLLISION),
    .ILLEGAL_CMD(ILLEGAL_CMD),
    .UNCLAIMED_CYCLE(UNCLAIMED_CYCLE),
    .DEVICE_TIMEOUT(DEVICE_TIMEOUT),
    .CMD_RUNNING(CMD_RUNNING),
    .ROUTE_TO_MGMT_IRQ(ROUTE_TO_MGMT_IRQ),
    .IRQ(IRQ),
    .SYSTEM_MGMT_IRQ_N(SYSTEM_MGMT_IRQ_N),
    .ADDR(ADDR),
    .RDATA(RDATA)
);
module tb_smbus_host_status_flags;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, nrst = 1'b0, rrst_n = 1'b1, rs = 1'b0, ws = 1'b0, alert_n = 1'b1, gpio = 1'b0;
    logic kill = 1'b0, ill = 1'b0, cie = 1'b0, route = 1'b0, byte_c = 1'b0, go = 1'b0, busy, irq, mgmt_n;
    logic [2:0] addr = 3'h0;
    logic [7:0] wd = 8'h00, rdata, d;
    logic [1:0] res = 2'h0;
    logic [3:0] ev;
    int n_errors = 0, checks = 0;
    logic [7:0] exp_t [10] = '{8'h10, 8'h04, 8'h08, 8'h04, 8'h04, 8'h02, 8'h20, 8'h80, 8'h00, 8'h00};
    always #4 clk = ~clk;
    shsf_slave slv_u (.clk(clk), .go(go), .res(res), .busy(busy), .ev(ev));
    shsf_top dut_u (.CLK(clk), .NRST(nrst), .RESUME_WELL_RESET_N(rrst_n), .ADDR(addr), .RD_STB(rs), .WR_STB(ws),
        .WDATA(wd), .RDATA(rdata), .ALERT_INPUT_N(alert_n), .ALERT_AS_GPIO(gpio), .KILL_REQ(kill),
        .COLLISION(ev[0]), .ILLEGAL_CMD(ill), .UNCLAIMED_CYCLE(ev[1]), .DEVICE_TIMEOUT(ev[2]), .CMD_SUCCESS(ev[3]),
        .COMPLETION_IRQ_ENABLE(cie), .BYTE_COMPLETE(byte_c), .CMD_RUNNING(busy), .ROUTE_TO_MGMT_IRQ(route),
        .IRQ(irq), .SYSTEM_MGMT_IRQ_N(mgmt_n));
    task automatic chk(input logic [7:0] s, e, input string n);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %s exp %h seen %h", n, e, s);
        end
    endtask
    // strobes rise 1ns after an edge and fall after the edge that takes them
    task automatic rd(output logic [7:0] v);
        @(posedge clk) #1 rs = 1'b1;
        @(posedge clk) #1 rs = 1'b0;
        v = rdata;
    endtask
    task automatic wr(input logic [7:0] v);
        @(posedge clk) #1 ws = 1'b1;
        wd = v;
        @(posedge clk) #1 ws = 1'b0;
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1 nrst = 1'b1;
        rd(d);
        chk(d, 8'h00, "sem first");
        rd(d);
        chk(d, 8'h40, "sem taken");
        wr(8'h00);
        rd(d);
        chk(d, 8'h40, "sem w0");
        wr(8'h40);
        rd(d);
        chk(d, 8'h00, "sem freed");
        rd(d);
        chk(irq, 8'h00, "sem irq");
        addr = 3'h7;
        rd(d);
        chk(d, 8'h00, "unmapped");
        addr = 3'h0;
        $display("test semaphore done");
        // one table row per flag source, then completion with irq disabled and alert as gpio, alternating the routing bit
        for (int k = 0; k < 10; k++) begin
            route = k[0];
            cie = k != 8;
            gpio = k == 9;
            @(posedge clk) #1;
            case (k)
                0: kill = 1'b1;
                1: ill = 1'b1;
                6, 9: alert_n = 1'b0;
                7: byte_c = 1'b1;
                default: begin
                    go = 1'b1;
                    res = k == 8 ? 2'h3 : 2'(k - 2);
                end
            endcase
            @(posedge clk) #1 {kill, ill, byte_c, go} = 4'h0;
            if (k inside {[2:5], 8}) begin
                rd(d);
                chk(d[0], 1'b1, "busy");
            end
            repeat (20) if (busy) @(posedge clk) #1;
            if (busy) begin
                n_errors++;
                break;
            end
            rd(d);
            chk(d, exp_t[k] | 8'h40, "flags");
            chk(irq, exp_t[k][5:1] != 0 && !route, "irq");
            chk(mgmt_n, !(exp_t[k][5:1] != 0 && route), "mgmt");
            alert_n = 1'b1;
            // zeros over a set flag leave it; the alert flag outlives its input
            wr(~exp_t[k] & 8'hBE);
            rd(d);
            chk(d, exp_t[k] | 8'h40, "flags kept");
            if (k == 6) begin
                rrst_n = 1'b0;
                @(posedge clk) #1 rrst_n = 1'b1;
            end
            else wr(exp_t[k] | 8'h3E);
            rd(d);
            chk(d, 8'h40, "cleared");
            chk({irq, mgmt_n}, 8'h01, "irq cleared");
            $display("test source %0d done", k);
        end
        summarize();
    end
endmodule
